// >>> mbr_mdio_slave.sv
`timescale 1ns/10ps
module mbr_mdio_slave import mbr_pkg::*; #(
  parameter logic [4:0] PHY_ADDR = MBR_PHY_ADDR_DEF
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic mdc,
  input wire logic mdio_in,
  output logic mdio_out,
  output logic mdio_oe,
  output logic cfg_wr_pulse,
  output logic [7:0] cfg_wr_addr,
  output logic [7:0] cfg_wr_data
);

  // Synchronised link pins
  logic [1:0] pin_sync;      // Clock and data after two stages
  logic mdc_prev;            // Clock level one cycle back

  // Frame sequencer
  mbr_state_type state;      // Current phase of the frame
  mbr_state_type next_state; // Phase after this clock
  logic [5:0] ones_cnt;      // Consecutive ones seen, saturating
  logic [3:0] bit_cnt;       // Bits left in current field
  logic [1:0] op_field;      // Op code
  logic [4:0] phy_address_field;      // PHY address
  logic [4:0] register_address_field; // Register address
  logic [15:0] shreg;        // Write data in, read data out
  logic wr_pulse;            // One-cycle store strobe
  logic [15:0] wr_word;      // Word to store

  // Access path to the register bank
  mbr_acc_if acc();

  // Clock and data pins both cross into the system clock
  mbr_sync #(.W(2)) u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .d({mdc, mdio_in}),
    .q(pin_sync)
  );

  // Register bank
  mbr_regbank u_bank (
    .clk(clk),
    .rst_n(rst_n),
    .acc(acc)
  );

  // Pin decode
  wire logic mdc_s = pin_sync[1];
  wire logic bit_in = pin_sync[0];
  // Rising edge of the management clock, at most one per period
  wire logic mdc_rise = mdc_s && !mdc_prev;

  // Field decode
  wire logic ones_full = ones_cnt == MBR_PRE_LEN;
  wire logic is_byte = op_field == MBR_OP_BYTE;
  // Byte frames choose direction from address bit 4
  wire logic is_read = is_byte ? phy_address_field[4] :
                       op_field == MBR_OP_RD;
  wire logic op_ok = is_byte || op_field == MBR_OP_RD ||
                     op_field == MBR_OP_WR;
  // Byte frames answer whatever PHY address is sent
  wire logic respond = op_ok &&
                       (is_byte || phy_address_field == PHY_ADDR);
  // Address bit 3 takes no part in the byte address
  wire logic [7:0] byte_addr = {phy_address_field[2:0],
                                register_address_field};
  // Listening while the device leaves the line to the controller
  wire logic listening = !mdio_oe;
  // A zero after a full preamble starts a frame from any phase while listening
  wire logic restart = listening && ones_full && !bit_in;
  wire logic [3:0] cnt_dec = bit_cnt - 4'h1;
  wire logic field_end = bit_cnt == 4'h0;
  wire logic commit = (state == MBR_DATA) && mdc_rise && field_end &&
                      !is_read;
  // Field length loaded on entering each phase
  wire logic [3:0] cnt_load = (next_state == MBR_OP) ? MBR_OP_BITS :
                              (next_state == MBR_DATA) ? MBR_DATA_MSB :
                              MBR_ADR_BITS;

  // Access path drive
  assign acc.acc_std = !is_byte;
  assign acc.acc_addr = is_byte ? byte_addr : {3'h0, register_address_field};
  assign acc.acc_wr = wr_pulse;
  assign acc.acc_wdata = wr_word;

  // Edge detector history
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mdc_prev <= 1'b0;
    end else begin
      mdc_prev <= mdc_s;
    end
  end

  // Preamble ones counter, only while the controller owns the line
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ones_cnt <= 6'h00;
    end else if (mdc_rise) begin
      if (!listening || !bit_in) begin
        ones_cnt <= 6'h00;
      end else if (!ones_full) begin
        ones_cnt <= ones_cnt + 6'h01;
      end
    end
  end

  // Next phase; both frame types share one sequence
  always_comb begin
    next_state = state;
    if (mdc_rise) begin
      if (restart) begin
        next_state = MBR_START;
      end else begin
        unique case (state)
          MBR_IDLE: begin
            next_state = MBR_IDLE;
          end
          MBR_START: begin
            // Second start bit must be one
            next_state = bit_in ? MBR_OP : MBR_IDLE;
          end
          MBR_OP: begin
            if (field_end) next_state = MBR_PHYA;
          end
          MBR_PHYA: begin
            if (field_end) next_state = MBR_REGA;
          end
          MBR_REGA: begin
            // Frames for another address or bad op are let pass
            if (field_end) next_state = respond ? MBR_TA1 : MBR_IDLE;
          end
          MBR_TA1: begin
            next_state = MBR_TA2;
          end
          MBR_TA2: begin
            next_state = MBR_DATA;
          end
          MBR_DATA: begin
            if (field_end) next_state = MBR_IDLE;
          end
        endcase
      end
    end
  end

  // Phase register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= MBR_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Field bit counter
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bit_cnt <= 4'h0;
    end else if (mdc_rise) begin
      if (state != next_state) begin
        bit_cnt <= cnt_load;
      end else if (!field_end) begin
        bit_cnt <= cnt_dec;
      end
    end
  end

  // Header fields shift in on rising edges
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      op_field <= 2'h0;
      phy_address_field <= 5'h00;
      register_address_field <= 5'h00;
    end else if (mdc_rise) begin
      if (state == MBR_OP) op_field <= {op_field[0], bit_in};
      if (state == MBR_PHYA) begin
        phy_address_field <= {phy_address_field[3:0], bit_in};
      end
      if (state == MBR_REGA) begin
        register_address_field <= {register_address_field[3:0], bit_in};
      end
    end
  end

  // Data shifter; write turnaround bits are not checked
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      shreg <= 16'h0000;
    end else if (mdc_rise) begin
      if (state == MBR_TA2 && is_read) begin
        shreg <= acc.acc_rdata;
      end else if (state == MBR_DATA && !is_read) begin
        shreg <= {shreg[14:0], bit_in};
      end
    end
  end

  // Store strobe after the last write bit
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_pulse <= 1'b0;
      wr_word <= 16'h0000;
    end else begin
      wr_pulse <= commit;
      if (commit) wr_word <= {shreg[14:0], bit_in};
    end
  end

  // Byte writes reported to the user side
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_wr_pulse <= 1'b0;
      cfg_wr_addr <= 8'h00;
      cfg_wr_data <= 8'h00;
    end else begin
      cfg_wr_pulse <= commit && is_byte;
      if (commit && is_byte) begin
        cfg_wr_addr <= byte_addr;
        cfg_wr_data <= bit_cnt == 4'h0 ? {shreg[6:0], bit_in} : 8'h00;
      end
    end
  end

  // Line driver: zero after first turnaround, then data MSB first
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mdio_oe <= 1'b0;
      mdio_out <= 1'b0;
    end else if (mdc_rise) begin
      if (state == MBR_TA1 && is_read) begin
        mdio_oe <= 1'b1;
        mdio_out <= 1'b0;
      end else if (state == MBR_TA2 && is_read) begin
        mdio_out <= acc.acc_rdata[15];
      end else if (state == MBR_DATA && is_read && !field_end) begin
        mdio_out <= shreg[cnt_dec];
      end else begin
        // Release after the last data bit
        mdio_oe <= 1'b0;
        mdio_out <= 1'b0;
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // Read turnaround steps
  sequence s_ta_turn;
    state == MBR_TA1 && mdc_rise && is_read;
  endsequence
  sequence s_drive_zero;
    (mdio_oe && !mdio_out) [*8];
  endsequence

  ta_zero_a: assert property (s_ta_turn |=> s_drive_zero)
    else $error("no zero driven on second turnaround bit");
  ta_float_a: assert property (state == MBR_TA1 |-> !mdio_oe)
    else $error("line driven in first turnaround bit");
  idle_float_a: assert property (
    (state == MBR_IDLE || state == MBR_START) |-> !mdio_oe)
    else $error("line driven while idle");
  high_byte_a: assert property (
    (state == MBR_DATA && is_byte && mdio_oe && bit_cnt > MBR_BYTE_MSB)
      |-> !mdio_out)
    else $error("byte read upper bit not zero");
  edge_only_a: assert property (
    ($changed(mdio_out) || $changed(mdio_oe)) |-> $past(mdc_rise))
    else $error("line changed away from a rising edge");
  pre_short_a: assert property (
    (state == MBR_IDLE && mdc_rise && !bit_in && !ones_full)
      |=> state == MBR_IDLE)
    else $error("frame started on short preamble");
  byte_wr_a: assert property (
    (commit && is_byte) |=>
      cfg_wr_pulse && cfg_wr_addr == $past(byte_addr))
    else $error("byte write address wrong or missing");
  byte_rd_a: assert property (
    (state == MBR_TA1 && mdc_rise && is_byte && phy_address_field[4])
      |=> mdio_oe)
    else $error("byte read not answered");
  byte_wr_quiet_a: assert property (
    (state == MBR_TA1 && mdc_rise && is_byte && !phy_address_field[4])
      |=> !mdio_oe)
    else $error("line driven during byte write");
  foreign_a: assert property (
    (state == MBR_REGA && mdc_rise && field_end && !restart && !respond)
      |=> (!mdio_oe && state == MBR_IDLE))
    else $error("frame for another address answered");
  // Unmapped reads answer zeros, so the first data bit must be low
  miss_zero_a: assert property (
    (state == MBR_TA2 && mdc_rise && is_read && !acc.acc_hit) |=> !mdio_out)
    else $error("unmapped read answered with a one");

endmodule

// >>> mbr_pkg.sv
package mbr_pkg;

  // Frame field lengths: preamble as a count up, the rest as counts down to zero
  localparam logic [5:0] MBR_PRE_LEN = 6'h20;  // Ones needed before start
  localparam logic [3:0] MBR_OP_BITS = 4'h1;   // Op code field, last index
  localparam logic [3:0] MBR_ADR_BITS = 4'h4;  // Address fields, last index
  localparam logic [3:0] MBR_DATA_MSB = 4'hf;  // Data field, first bit
  localparam logic [3:0] MBR_BYTE_MSB = 4'h7;  // Top bit of byte content

  // Op codes
  localparam logic [1:0] MBR_OP_RD = 2'h2;     // Standard read
  localparam logic [1:0] MBR_OP_WR = 2'h1;     // Standard write
  localparam logic [1:0] MBR_OP_BYTE = 2'h0;   // Byte register frame

  // Register space
  localparam int MBR_CFG_DEPTH = 199;          // Configuration bytes
  localparam logic [7:0] MBR_CFG_LAST = 8'hc6; // Highest config address
  localparam logic [3:0] MBR_IND_HI = 4'hf;    // Indirect PHY window page
  localparam logic [4:0] MBR_STD_LAST = 5'h05; // Last low standard reg
  localparam logic [4:0] MBR_REG_C1 = 5'h1d;   // First custom register
  localparam logic [4:0] MBR_REG_C2 = 5'h1f;   // Second custom register
  localparam logic [2:0] MBR_IDX_C1 = 3'h6;    // Slot of first custom
  localparam logic [2:0] MBR_IDX_C2 = 3'h7;    // Slot of second custom

  // Reset values
  localparam logic [7:0] MBR_CFG_RST = 8'h00;
  localparam logic [15:0] MBR_PHY_RST = 16'h0000;
  localparam logic [4:0] MBR_PHY_ADDR_DEF = 5'h01; // Default own address

  // Timing: fastest management clock and its shortest period in cycles
  localparam int MBR_CLK_HZ = 100_000_000;
  localparam int MBR_MDC_MAX_HZ = 5_000_000;
  localparam int MBR_MDC_MIN_CLKS = MBR_CLK_HZ / MBR_MDC_MAX_HZ;

  // Frame sequencer states
  typedef enum logic [7:0] {
    MBR_IDLE = 8'h01,
    MBR_START = 8'h02,
    MBR_OP = 8'h04,
    MBR_PHYA = 8'h08,
    MBR_REGA = 8'h10,
    MBR_TA1 = 8'h20,
    MBR_TA2 = 8'h40,
    MBR_DATA = 8'h80
  } mbr_state_type;

endpackage

// >>> mbr_acc_if.sv
`timescale 1ns/10ps
// Register access path from the frame sequencer to the register bank
interface mbr_acc_if;
  logic acc_std;          // Standard frame, else byte frame
  logic [7:0] acc_addr;   // Byte address, or register number in low bits
  logic acc_wr;           // One-cycle write strobe
  logic [15:0] acc_wdata; // Write word
  logic [15:0] acc_rdata; // Read word
  logic acc_hit;          // Address maps to storage
  modport master(output acc_std, acc_addr, acc_wr, acc_wdata,
                 input acc_rdata, acc_hit);
  modport bank(input acc_std, acc_addr, acc_wr, acc_wdata,
               output acc_rdata, acc_hit);
endinterface

// >>> mbr_sync.sv
`timescale 1ns/10ps
// Two-stage synchroniser for pin inputs
module mbr_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta; // First stage, read only by the second

  // Both stages clear on reset
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta <= '0;
      q <= '0;
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule

// >>> mbr_regbank.sv
`timescale 1ns/10ps
// Eight PHY words and the configuration byte space
module mbr_regbank import mbr_pkg::*; (
  input wire logic clk,
  input wire logic rst_n,
  mbr_acc_if.bank acc
);
  logic [7:0] cfg_mem [MBR_CFG_DEPTH]; // Configuration bytes
  logic [15:0] phy_mem [8];            // PHY words

  // Standard register number to slot
  wire logic [4:0] reg_no = acc.acc_addr[4:0];
  wire logic is_c1 = reg_no == MBR_REG_C1;
  wire logic is_c2 = reg_no == MBR_REG_C2;
  wire logic std_hit = (reg_no <= MBR_STD_LAST) || is_c1 || is_c2;
  wire logic [2:0] std_idx = is_c1 ? MBR_IDX_C1 :
                             is_c2 ? MBR_IDX_C2 : reg_no[2:0];
  // Byte space decode: config bytes and indirect PHY window
  wire logic cfg_hit = !acc.acc_std && acc.acc_addr <= MBR_CFG_LAST;
  wire logic ind_hit = !acc.acc_std && acc.acc_addr[7:4] == MBR_IND_HI;
  wire logic [2:0] phy_idx = acc.acc_std ? std_idx : acc.acc_addr[3:1];
  wire logic [15:0] phy_word = phy_mem[phy_idx];
  wire logic [7:0] ind_byte = acc.acc_addr[0] ? phy_word[15:8] : phy_word[7:0];
  wire logic [7:0] cfg_byte = cfg_hit ? cfg_mem[acc.acc_addr] : 8'h00;

  assign acc.acc_hit = (acc.acc_std && std_hit) || cfg_hit || ind_hit;
  // Byte reads carry zeros above the byte
  assign acc.acc_rdata = acc.acc_std ? (std_hit ? phy_word : 16'h0000) :
                         ind_hit ? {8'h00, ind_byte} :
                         {8'h00, cfg_byte};

  // Writes; byte frames store only the low byte
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < MBR_CFG_DEPTH; i++) cfg_mem[i] <= MBR_CFG_RST;
      for (int j = 0; j < 8; j++) phy_mem[j] <= MBR_PHY_RST;
    end else if (acc.acc_wr) begin
      if (cfg_hit) cfg_mem[acc.acc_addr] <= acc.acc_wdata[7:0];
      if (acc.acc_std && std_hit) phy_mem[phy_idx] <= acc.acc_wdata;
      if (ind_hit && acc.acc_addr[0]) begin
        phy_mem[phy_idx][15:8] <= acc.acc_wdata[7:0];
      end
      if (ind_hit && !acc.acc_addr[0]) begin
        phy_mem[phy_idx][7:0] <= acc.acc_wdata[7:0];
      end
    end
  end

  byte_store_a: assert property (@(posedge clk) disable iff (!rst_n)
    (acc.acc_wr && cfg_hit) |=>
      cfg_mem[$past(acc.acc_addr)] == $past(acc.acc_wdata[7:0]))
    else $error("config byte not stored from low data bits");
  byte_read_a: assert property (@(posedge clk) disable iff (!rst_n)
    !acc.acc_std |-> acc.acc_rdata[15:8] == 8'h00)
    else $error("byte read upper bits not zero");
endmodule

// >>> mbr_mgmt_ctrl.sv
`timescale 1ns/10ps
// Controller model: owns the management clock and its half of the data line
module mbr_mgmt_ctrl (
  input wire logic clk,
  input wire logic line,
  output logic mdc,
  output logic drv_en,
  output logic drv_val
);
  int half = 8;  // Clock cycles per half period of the management clock
  logic ta_bit;  // Level seen at the second turnaround bit of the last frame

  // Clock stands low and the line is released outside frames
  initial begin
    mdc = 1'b0;
    drv_en = 1'b0;
    drv_val = 1'b0;
    ta_bit = 1'b1;
  end

  // One bit time: set data while low, raise clock, sample at the rise
  task automatic bit_time(input logic en, input logic val, output logic smp);
    @(negedge clk);
    mdc = 1'b0;
    drv_en = en;
    drv_val = val;
    repeat (half) @(negedge clk);
    mdc = 1'b1;
    smp = line;
    repeat (half - 1) @(negedge clk);
  endtask

  // Release the line and stop the clock
  task automatic idle(input int n);
    @(negedge clk);
    mdc = 1'b0;
    drv_en = 1'b0;
    repeat (n) @(negedge clk);
  endtask

  // Whole frame; reads float the line from the first turnaround bit
  task automatic frame(input int pre, input logic [1:0] op,
      input logic [4:0] phy, input logic [4:0] rg, input logic [15:0] wd,
      output logic [15:0] rd);
    logic [13:0] hdr;
    logic s;
    logic rdg;
    hdr = {2'b01, op, phy, rg};
    rdg = (op == 2'b10) || (op == 2'b00 && phy[4]);
    rd = 16'h0000;
    for (int i = 0; i < pre; i++) bit_time(1'b1, 1'b1, s);
    for (int i = 13; i >= 0; i--) bit_time(1'b1, hdr[i], s);
    bit_time(!rdg, 1'b1, s);
    bit_time(!rdg, 1'b0, ta_bit);
    for (int i = 15; i >= 0; i--) begin
      bit_time(!rdg, wd[i], s);
      rd[i] = s;
    end
    idle(4);
  endtask
endmodule

// >>> mdio_mgmt_and_byte_register_port_tb_top.sv
`timescale 1ns/10ps
// Bench for the management slave with a controller model on the far side
module mdio_mgmt_and_byte_register_port_tb_top;
  import mbr_pkg::*;
  logic clk, rst_n, mdc, drv_en, drv_val, line;
  logic mdio_out, mdio_oe, cfg_wr_pulse, saw_oe, s;
  logic [7:0] cfg_wr_addr, cfg_wr_data, last_addr, last_data;
  logic [15:0] rd;  // Word returned by the last frame
  int miscompares = 0;
  int compares = 0;
  int cycles = 0;
  int pulses = 0;  // Write pulses seen
  int run = 0;  // Length of the current pulse
  int pulse_len = 0;  // Longest pulse seen

  // Line has a pull-up; device drive wins, else controller, else high
  assign line = mdio_oe ? mdio_out : (drv_en ? drv_val : 1'b1);

  mbr_mdio_slave dut_u (.clk(clk), .rst_n(rst_n), .mdc(mdc),
    .mdio_in(line), .mdio_out(mdio_out), .mdio_oe(mdio_oe),
    .cfg_wr_pulse(cfg_wr_pulse), .cfg_wr_addr(cfg_wr_addr),
    .cfg_wr_data(cfg_wr_data));

  mbr_mgmt_ctrl ctrl_u (.clk(clk), .line(line), .mdc(mdc),
    .drv_en(drv_en), .drv_val(drv_val));

  // System clock, 100 MHz
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Watches write pulses, drive clashes and the run time
  always @(negedge clk) begin
    cycles++;
    run = (cfg_wr_pulse === 1'b1) ? run + 1 : 0;
    if (run == 1) begin
      pulses++;
      last_addr = cfg_wr_addr;
      last_data = cfg_wr_data;
    end
    if (run > pulse_len) pulse_len = run;
    if (mdio_oe === 1'b1) saw_oe = 1'b1;
    if (mdio_oe === 1'b1 && drv_en === 1'b1) begin
      miscompares++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, 1, 0);
    end
    if (cycles == 90000) begin
      miscompares++;
      print_verdict();
    end
  end

  // Compares a design word
  task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Compares a bench count
  task automatic chk_cnt(input int got, input int exp);
    chk_val(16'(got), 16'(exp));
  endtask

  // Byte frames and a standard read; address bit 3 of the PHY field is a free choice
  task automatic byte_wr(input logic [7:0] a, input logic [15:0] d,
      input logic b3);
    ctrl_u.frame(32, MBR_OP_BYTE, {1'b0, b3, a[7:5]}, a[4:0], d, rd);
  endtask
  task automatic byte_rd(input logic [7:0] a, input logic b3);
    ctrl_u.frame(32, MBR_OP_BYTE, {1'b1, b3, a[7:5]}, a[4:0], 16'h0, rd);
  endtask
  task automatic std_rd(input logic [4:0] phy, input logic [4:0] r);
    saw_oe = 1'b0;
    ctrl_u.frame(32, MBR_OP_RD, phy, r, 16'h0, rd);
  endtask

  // Standard registers written, then read back with the turnaround zero
  task automatic t_std_regs();
    logic [4:0] regs [9] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h05,
      5'h1d, 5'h1f, 5'h06};
    saw_oe = 1'b0;
    for (int i = 0; i < 9; i++) begin
      ctrl_u.frame(32, MBR_OP_WR, 5'h01, regs[i], 16'ha5c0 + 16'(i), rd);
    end
    chk_val({15'h0, saw_oe}, 16'h0000);
    for (int i = 0; i < 9; i++) begin
      std_rd(5'h01, regs[i]);
      chk_val(rd, (i < 8) ? 16'ha5c0 + 16'(i) : 16'h0000);
      chk_val({15'h0, ctrl_u.ta_bit}, 16'h0000);
      chk_val({15'h0, mdio_oe}, 16'h0000);
    end
  endtask

  // Byte writes strobe out the low byte; reads clear the upper byte
  task automatic t_byte();
    int p;
    p = pulses;
    byte_wr(8'h25, 16'hff5a, 1'b1);
    chk_cnt(pulses, p + 1);
    chk_cnt(pulse_len, 1);
    chk_val({8'h00, last_addr}, 16'h0025);
    chk_val({8'h00, last_data}, 16'h005a);
    byte_rd(8'h25, 1'b0);
    chk_val(rd, 16'h005a);
    byte_wr(8'h00, 16'h3c81, 1'b0);
    byte_wr(8'hc6, 16'h00e7, 1'b1);
    byte_wr(8'hc7, 16'h0011, 1'b0);
    chk_val({8'h00, last_addr}, 16'h00c7);
    byte_rd(8'h00, 1'b1);
    chk_val(rd, 16'h0081);
    byte_rd(8'hc6, 1'b0);
    chk_val(rd, 16'h00e7);
    byte_rd(8'hc7, 1'b0);
    chk_val(rd, 16'h0000);
  endtask

  // PHY words reached through the byte window
  task automatic t_indirect();
    byte_wr(8'hf0, 16'h0034, 1'b0);
    byte_wr(8'hf1, 16'h0012, 1'b1);
    std_rd(5'h01, 5'h00);
    chk_val(rd, 16'h1234);
    ctrl_u.frame(32, MBR_OP_WR, 5'h01, 5'h1f, 16'hbeef, rd);
    byte_rd(8'hff, 1'b0);
    chk_val(rd, 16'h00be);
    byte_rd(8'hfe, 1'b1);
    chk_val(rd, 16'h00ef);
  endtask

  // Foreign address, bad op code and short preamble are all ignored
  task automatic t_refuse();
    int p;
    std_rd(5'h02, 5'h00);
    chk_val({15'h0, saw_oe}, 16'h0000);
    ctrl_u.frame(32, MBR_OP_WR, 5'h02, 5'h00, 16'h0000, rd);
    ctrl_u.frame(32, 2'b11, 5'h01, 5'h00, 16'h0000, rd);
    p = pulses;
    ctrl_u.frame(31, MBR_OP_BYTE, 5'h00, 5'h10, 16'h0077, rd);
    chk_cnt(pulses, p);
    std_rd(5'h01, 5'h00);
    chk_val(rd, 16'h1234);
    byte_rd(8'h10, 1'b0);
    chk_val(rd, 16'h0000);
  endtask

  // Frame cut short, then a full preamble resynchronises
  task automatic t_abort();
    logic [6:0] part;
    part = 7'b0100001;
    for (int i = 0; i < 32; i++) ctrl_u.bit_time(1'b1, 1'b1, s);
    for (int i = 6; i >= 0; i--) ctrl_u.bit_time(1'b1, part[i], s);
    ctrl_u.idle(20);
    byte_wr(8'h11, 16'h0066, 1'b0);
    chk_val({last_addr, last_data}, 16'h1166);
    byte_rd(8'h11, 1'b0);
    chk_val(rd, 16'h0066);
  endtask

  // Fastest and slow management clocks, then a reset in mid-run
  task automatic t_speed_reset();
    ctrl_u.half = 10;
    byte_wr(8'h42, 16'h0099, 1'b0);
    byte_rd(8'h42, 1'b0);
    chk_val(rd, 16'h0099);
    ctrl_u.half = 30;
    byte_rd(8'h42, 1'b1);
    chk_val(rd, 16'h0099);
    ctrl_u.half = 8;
    rst_n = 1'b0;
    repeat (4) @(negedge clk);
    chk_val({14'h0, mdio_oe, cfg_wr_pulse}, 16'h0000);
    chk_val({cfg_wr_addr, cfg_wr_data}, 16'h0000);
    rst_n = 1'b1;
    repeat (4) @(negedge clk);
    byte_rd(8'h42, 1'b0);
    chk_val(rd, 16'h0000);
    std_rd(5'h01, 5'h00);
    chk_val(rd, 16'h0000);
  endtask

  // Prints the counts and the verdict, then ends the run
  task automatic print_verdict();
    $display("compares=%0d miscompares=%0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    rst_n = 1'b0;
    saw_oe = 1'b0;
    repeat (4) @(negedge clk);
    rst_n = 1'b1;
    repeat (4) @(negedge clk);
    t_std_regs();
    t_byte();
    t_indirect();
    t_refuse();
    t_abort();
    t_speed_reset();
    print_verdict();
  end
endmodule
